// ---- adcs_pkg.sv ----
package adcs_pkg;

  // ----------------------------------------------------------------
  // Conversion counter landmarks (BCD counts, held as binary)
  // ----------------------------------------------------------------
  localparam int unsigned CNT_W          = 16;
  localparam logic [15:0] CNT_HOLD       = 16'h4e20;  // 20,000
  localparam logic [15:0] CNT_AZ_END     = 16'h7530;  // 30,000
  localparam logic [15:0] CNT_WRAP       = 16'h9c3f;  // 39,999
  localparam logic [15:0] CNT_OVR        = 16'h4e20;  // 20,000
  localparam int unsigned NUM_DIGITS     = 5;

  // ----------------------------------------------------------------
  // Timing, in oscillator (clk_i) cycles
  // ----------------------------------------------------------------
  localparam int unsigned COUNT_DIV      = 2;
  localparam int unsigned HOLD_SAMPLE_CLKS = 4000;
  localparam int unsigned MUX_DIV_CLKS   = 200;

  // ----------------------------------------------------------------
  // Register map (byte offsets) and fields
  // ----------------------------------------------------------------
  localparam logic [3:0] REG_CTRL        = 4'h0;
  localparam logic [3:0] REG_STATUS      = 4'h4;
  localparam logic [3:0] REG_RESULT      = 4'h8;
  localparam logic [3:0] REG_COUNT       = 4'hc;
  localparam int unsigned CTRL_HOLD_BIT  = 0;
  localparam int unsigned CTRL_BLANK_BIT = 1;
  localparam logic [1:0]  CTRL_RESET     = 2'h0;
  localparam int unsigned STAT_PHASE_LSB = 0;
  localparam int unsigned STAT_POL_BIT   = 2;
  localparam int unsigned STAT_OVR_BIT   = 3;
  localparam int unsigned STAT_TRIG_BIT  = 4;
  localparam int unsigned STAT_CMP_BIT   = 5;

  typedef enum logic [1:0] {
    PH_AZ     = 2'h0,
    PH_HOLD   = 2'h1,
    PH_INT_IN = 2'h3,
    PH_INT_RF = 2'h2
  } adcs_phase_e;

  typedef struct packed {
    logic a;
    logic b;
  } adcs_ctl_s;

  typedef struct packed {
    logic                  sign;  // 1 = positive input
    logic                  ovr;
    logic [4:0][3:0]       dig;   // dig[4] is the half digit
  } adcs_res_s;

  localparam adcs_res_s RES_RESET = '0;

endpackage

// ---- adcs_seq.sv ----
// The address map and the Avalon-MM slave port were left to the implementer.
`timescale 1ns/1ps
// Behaviour
// [RULE1] Conversion counter advances once every two oscillator cycles.
// [RULE2] Each conversion runs auto-zero, integrate-input, integrate-reference in turn.
// [RULE3] Reference phase end starts auto-zero with both control lines low.
// [RULE4] Trigger high during auto-zero: conversions run back to back.
// [RULE5] Trigger low during auto-zero: counter stops at 20,000, hold state.
// [RULE6] In hold, trigger is sampled every 4000 oscillator pulses.
// [RULE7] Trigger found high in hold: counting resumes, auto-zero until 30,000.
// [RULE8] At 30,000 auto-zero ends, both control lines high.
// [RULE9] Integrate-input lasts exactly 10,000 counts.
// [RULE10] Rollover 39,999 to 0 samples comparator, starts reference phase.
// [RULE11] Comparator low (negative): first line low, second high.
// [RULE12] Comparator high (positive): first line high, second low.
// [RULE13] Zero crossing ends reference phase, count copied to result.
// [RULE14] Count 20,000 in reference phase without crossing: end, flag over-range.
// [RULE15] Over-range blanks all digits but the most significant and sign.
// [RULE16] Result latched in parallel into buffer at each conversion end.
// [RULE17] Digits multiplexed out one at a time at oscillator over 200.
// [RULE18] Open or high trigger means run; other party holds it low for hold.
// [RULE19] Comparator ignored in auto-zero; used only at sample and reference.
// [RULE20] Power-up: auto-zero, counter zero, lines low, no over-range.
module adcs_seq
  import adcs_pkg::*;
#(
  parameter int unsigned HOLD_SAMPLE = HOLD_SAMPLE_CLKS,
  parameter int unsigned MUX_DIV     = MUX_DIV_CLKS
) (
  input  wire logic        clk_i,               // Oscillator clock, 125 MHz
  input  wire logic        nrst_i,              // Async reset, active low
  input  wire logic        trigger_i,           // Run/hold pin, high or open = run
  input  wire logic        comparator_i,        // Front-end comparator output
  output adcs_ctl_s        phase_ctl_o,         // Phase-select lines A/B
  output logic [4:0]       digit_en_o,          // One-hot digit enable
  output logic [3:0]       bcd_o,               // BCD of enabled digit
  output logic             sign_o,              // Result sign, 1 = positive
  output logic             over_range_o,        // Over-range indication
  input  wire logic [3:0]  avs_address,         // Byte address
  input  wire logic        avs_read,            // Read request
  input  wire logic        avs_write,           // Write request
  input  wire logic [31:0] avs_writedata,       // Write data
  input  wire logic [3:0]  avs_byteenable,      // Byte enables
  output logic [31:0]      avs_readdata,        // Read data
  output logic             avs_waitrequest      // Stall until answer ready
);

  // ----------------------------------------------------------------
  // Pin synchronisers
  // ----------------------------------------------------------------
  logic [2:0] trig_s_r;
  logic [2:0] cmp_s_r;
  logic       trig_f_r;
  logic       cmp_f_r;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      trig_s_r <= 3'h7;
      cmp_s_r  <= 3'h0;
    end else begin
      trig_s_r <= {trig_s_r[1:0], trigger_i};
      cmp_s_r  <= {cmp_s_r[1:0], comparator_i};
    end
  end

  // A level counts only once two late stages agree
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      trig_f_r <= 1'b1;
      cmp_f_r  <= 1'b0;
    end else begin
      if (trig_s_r[2] == trig_s_r[1]) begin
        trig_f_r <= trig_s_r[2];
      end
      if (cmp_s_r[2] == cmp_s_r[1]) begin
        cmp_f_r <= cmp_s_r[2];
      end
    end
  end

  // ----------------------------------------------------------------
  // Register state
  // ----------------------------------------------------------------
  logic [1:0] ctrl_r;
  logic       trig_run;

  // Software hold is ANDed in so a bench can park the sequencer
  assign trig_run = trig_f_r & ~ctrl_r[CTRL_HOLD_BIT];  // RULE18

  // ----------------------------------------------------------------
  // Rate dividers
  // ----------------------------------------------------------------
  localparam int unsigned HOLD_W = $clog2(HOLD_SAMPLE);
  localparam int unsigned MUX_W  = $clog2(MUX_DIV);

  logic              step_r;
  logic [HOLD_W-1:0] hold_cnt_r;
  logic              hold_tick;
  logic [MUX_W-1:0]  mux_cnt_r;
  logic              mux_tick;
  adcs_phase_e       phase_r;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      step_r <= 1'b0;
    end else begin
      step_r <= ~step_r;  // RULE1
    end
  end

  assign hold_tick = (hold_cnt_r == HOLD_W'(HOLD_SAMPLE - 1));

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      hold_cnt_r <= '0;
    end else if (phase_r != PH_HOLD || hold_tick) begin
      hold_cnt_r <= '0;
    end else begin
      hold_cnt_r <= hold_cnt_r + 1'b1;  // RULE6
    end
  end

  assign mux_tick = (mux_cnt_r == MUX_W'(MUX_DIV - 1));

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      mux_cnt_r <= '0;
    end else if (mux_tick) begin
      mux_cnt_r <= '0;
    end else begin
      mux_cnt_r <= mux_cnt_r + 1'b1;  // RULE17
    end
  end

  // ----------------------------------------------------------------
  // Conversion counter and phase sequencer
  // ----------------------------------------------------------------
  function automatic logic [4:0][3:0] bcd_inc(input logic [4:0][3:0] d);
    logic [4:0][3:0] q;
    logic            c;
    q = d;
    c = 1'b1;
    for (int i = 0; i < NUM_DIGITS; i++) begin
      if (c) begin
        if (q[i] == 4'h9) begin
          q[i] = 4'h0;
        end else begin
          q[i] = q[i] + 4'h1;
          c    = 1'b0;
        end
      end
    end
    return q;
  endfunction

  logic [CNT_W-1:0] bin_r;
  logic [4:0][3:0]  dig_r;
  logic             pol_r;
  adcs_ctl_s        ctl_r;
  adcs_res_s        res_r;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      phase_r <= PH_AZ;  // RULE20
      bin_r   <= '0;
      dig_r   <= '0;
      pol_r   <= 1'b0;
      ctl_r   <= '0;
      res_r   <= RES_RESET;
    end else begin
      case (phase_r)
        PH_AZ: begin
          // Comparator limit-cycles here, so it is not looked at
          if (step_r) begin  // RULE19
            if (bin_r == CNT_HOLD && !trig_run) begin
              phase_r <= PH_HOLD;  // RULE5
            end else begin
              bin_r <= bin_r + 1'b1;  // RULE4
              dig_r <= bcd_inc(dig_r);
              if (bin_r == CNT_AZ_END - 16'h1) begin
                phase_r <= PH_INT_IN;  // RULE8
                ctl_r   <= '{a: 1'b1, b: 1'b1};
              end
            end
          end
        end
        PH_HOLD: begin
          if (hold_tick && trig_run) begin
            phase_r <= PH_AZ;  // RULE7
          end
        end
        PH_INT_IN: begin
          if (step_r) begin
            if (bin_r == CNT_WRAP) begin
              // Fixed 30,000..39,999 window gives 10,000 counts
              bin_r   <= '0;  // RULE9
              dig_r   <= '0;
              pol_r   <= cmp_f_r;  // RULE10
              phase_r <= PH_INT_RF;  // RULE2
              if (cmp_f_r) begin
                ctl_r <= '{a: 1'b1, b: 1'b0};  // RULE12
              end else begin
                ctl_r <= '{a: 1'b0, b: 1'b1};  // RULE11
              end
            end else begin
              bin_r <= bin_r + 1'b1;
              dig_r <= bcd_inc(dig_r);
            end
          end
        end
        PH_INT_RF: begin
          if (step_r) begin
            if (cmp_f_r != pol_r) begin
              res_r   <= '{sign: pol_r, ovr: 1'b0, dig: dig_r};  // RULE13 RULE16
              phase_r <= PH_AZ;
              ctl_r   <= '0;  // RULE3
            end else if (bin_r == CNT_OVR - 16'h1) begin
              // The step onto 20,000 closes the phase, so the reference never overruns
              bin_r   <= CNT_OVR;
              dig_r   <= bcd_inc(dig_r);
              res_r   <= '{sign: pol_r, ovr: 1'b1, dig: bcd_inc(dig_r)};  // RULE14 RULE16
              phase_r <= PH_AZ;
              ctl_r   <= '0;  // RULE3
            end else begin
              bin_r <= bin_r + 1'b1;
              dig_r <= bcd_inc(dig_r);
            end
          end
        end
        default: begin
          phase_r <= PH_AZ;
          ctl_r   <= '0;
        end
      endcase
    end
  end

  assign phase_ctl_o  = ctl_r;
  assign over_range_o = res_r.ovr;

  // ----------------------------------------------------------------
  // Display multiplexer
  // ----------------------------------------------------------------
  logic [2:0] scan_r;
  logic       blank;

  // Over-range leaves only the half digit lit; sign stays valid
  assign blank = ctrl_r[CTRL_BLANK_BIT] || (res_r.ovr && scan_r != 3'h4);  // RULE15

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      scan_r     <= 3'h0;
      digit_en_o <= 5'h00;
      bcd_o      <= 4'h0;
      sign_o     <= 1'b0;
    end else if (mux_tick) begin
      scan_r     <= (scan_r == 3'h4) ? 3'h0 : scan_r + 3'h1;  // RULE17
      digit_en_o <= blank ? 5'h00 : 5'(5'h01 << scan_r);
      bcd_o      <= blank ? 4'hf : res_r.dig[scan_r];
      sign_o     <= res_r.sign;
    end
  end

  // ----------------------------------------------------------------
  // Avalon-MM slave: one wait state on every access
  // ----------------------------------------------------------------
  logic ack_r;
  logic req;

  assign req             = avs_read | avs_write;
  assign avs_waitrequest = req & ~ack_r;

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ack_r <= 1'b0;
    end else begin
      ack_r <= req & ~ack_r;
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      ctrl_r <= CTRL_RESET;
    end else if (avs_write && ack_r && avs_address == REG_CTRL && avs_byteenable[0]) begin
      ctrl_r <= avs_writedata[1:0];
    end
  end

  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      avs_readdata <= 32'h0;
    end else if (avs_read && !ack_r) begin
      case (avs_address)
        REG_CTRL:   avs_readdata <= {30'h0, ctrl_r};
        REG_STATUS: avs_readdata <= {26'h0, cmp_f_r, trig_f_r, res_r.ovr, pol_r, phase_r};
        REG_RESULT: avs_readdata <= {10'h0, res_r};
        REG_COUNT:  avs_readdata <= {16'h0, bin_r};
        default:    avs_readdata <= 32'h0;
      endcase
    end
  end

endmodule

// ---- adcs_seq_chk_assertions.sv ----
`timescale 1ns/1ps
module adcs_seq_chk
  import adcs_pkg::*;
(
  input wire logic       clk_i,            // Clock
  input wire logic       nrst_i,           // Reset, active low
  input wire logic       comparator_i,     // Front-end comparator
  input wire adcs_ctl_s  phase_ctl_o,      // Phase lines
  input wire logic [4:0] digit_en_o,       // Digit enables
  input wire logic       over_range_o,     // Over-range flag
  input wire logic       avs_read,         // Bus read
  input wire logic       avs_waitrequest   // Bus stall
);
  // ----------------------------------------------------------------
  // Phase length counters, in clocks
  // ----------------------------------------------------------------
  logic [15:0] in_r;
  logic [15:0] rf_r;
  always_ff @(posedge clk_i or negedge nrst_i) begin
    if (!nrst_i) begin
      in_r <= '0;
      rf_r <= '0;
    end else begin
      in_r <= (phase_ctl_o == 2'b11) ? in_r + 16'h1 : 16'h0;
      rf_r <= (phase_ctl_o.a != phase_ctl_o.b) ? rf_r + 16'h1 : 16'h0;
    end
  end
  default clocking @(posedge clk_i); endclocking
  default disable iff (!nrst_i);
  chk_in_length: assert property (phase_ctl_o != 2'b11 && in_r != 0 |-> in_r == 16'h4e20)
    else $error("input phase length wrong");
  chk_az_to_in: assert property (phase_ctl_o == 2'b11 && $changed(phase_ctl_o)
    |-> $past(phase_ctl_o) == 2'b00) else $error("input phase not entered from auto-zero");
  chk_ref_polarity: assert property ($past(phase_ctl_o) == 2'b11
    && phase_ctl_o != 2'b11
    |-> phase_ctl_o == {$past(comparator_i, 8), !$past(comparator_i, 8)})
    else $error("reference polarity wrong");
  chk_ref_to_az: assert property ($past(phase_ctl_o.a) != $past(phase_ctl_o.b)
    && $changed(phase_ctl_o) |-> phase_ctl_o == 2'b00) else $error("reference end not auto-zero");
  // Six samples cover the three synchroniser stages, the filter stage and one two-clock step
  chk_cross_end: assert property ((phase_ctl_o.a != phase_ctl_o.b
    && comparator_i != phase_ctl_o.a)[*6] |=> phase_ctl_o == 2'b00)
    else $error("zero crossing ignored");
  chk_ref_bound: assert property (rf_r <= 16'h9c40)
    else $error("reference phase too long");
  chk_reset_state: assert property ($rose(nrst_i)
    |-> phase_ctl_o == 2'b00 && !over_range_o && digit_en_o == 5'h0) else $error("bad reset state");
  chk_digit_onehot: assert property ($onehot0(digit_en_o))
    else $error("more than one digit enabled");
  chk_bus_wait: assert property ($rose(avs_read) |-> avs_waitrequest ##1 !avs_waitrequest)
    else $error("read wait state wrong");
endmodule

// ---- adcs_fe_model.sv ----
`timescale 1ns/1ps
module adcs_fe_model
  import adcs_pkg::*;
(
  input wire logic        clk_i,        // Clock
  input wire adcs_ctl_s   phase_ctl_i,  // Phase lines from sequencer
  input wire logic        positive_i,   // Sign of the modelled input
  input wire logic [15:0] ref_steps_i,  // Counts until zero crossing
  output logic            comp_o        // Comparator output
);
  // ----------------------------------------------------------------
  // Integrator seen through its comparator
  // ----------------------------------------------------------------
  logic [16:0] rf_r;
  always_ff @(posedge clk_i) begin
    rf_r <= (phase_ctl_i.a == phase_ctl_i.b) ? 17'h0 : rf_r + 17'h1;
  end
  always_ff @(posedge clk_i) begin
    case (phase_ctl_i)
      2'b00: comp_o <= (comp_o !== 1'b1);
      2'b11: comp_o <= positive_i;
      // Ramp back crosses zero after the requested number of counts
      default: comp_o <= (rf_r < {ref_steps_i, 1'b0}) ? positive_i : !positive_i;
    endcase
  end
endmodule

// ---- testbench.sv ----
`timescale 1ns/1ps
module testbench;
  import adcs_pkg::*;
  logic        clk_i, nrst_i, trigger_i, comparator_i, sign_o, over_range_o, pos;
  logic        avs_read, avs_write, avs_waitrequest;
  logic [3:0]  avs_address, avs_byteenable, bcd_o;
  logic [31:0] avs_writedata, avs_readdata, expv;
  logic [4:0]  digit_en_o;
  logic [15:0] ref_steps;
  logic [63:0] notes[$];
  logic [63:0] nt;
  adcs_ctl_s   phase_ctl_o;
  int          failures, samples_checked;
  adcs_seq #(.HOLD_SAMPLE(8), .MUX_DIV(4)) i_adcs_seq (.clk_i(clk_i), .nrst_i(nrst_i),
    .trigger_i(trigger_i), .comparator_i(comparator_i), .phase_ctl_o(phase_ctl_o),
    .digit_en_o(digit_en_o), .bcd_o(bcd_o), .sign_o(sign_o), .over_range_o(over_range_o),
    .avs_address(avs_address), .avs_read(avs_read), .avs_write(avs_write),
    .avs_writedata(avs_writedata), .avs_byteenable(avs_byteenable),
    .avs_readdata(avs_readdata), .avs_waitrequest(avs_waitrequest));
  adcs_fe_model i_adcs_fe_model (.clk_i(clk_i), .phase_ctl_i(phase_ctl_o), .positive_i(pos),
    .ref_steps_i(ref_steps), .comp_o(comparator_i));
  initial begin
    clk_i = 1'b0;
    forever #4 clk_i = ~clk_i;
  end
  task automatic check(string what, logic [31:0] exp, logic [31:0] got);
    samples_checked++;
    if (exp !== got) begin
      failures++;
      $display("wrong value %s expected %h seen %h", what, exp, got);
    end
  endtask
  task automatic tally_and_finish();
    $display("checks %0d mismatches %0d", samples_checked, failures);
    if (failures == 0 && samples_checked > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // ----------------------------------------------------------------
  // Bus master; a read notes its expected value for the monitor
  // ----------------------------------------------------------------
  task automatic bus(logic wr, logic [3:0] a, logic [31:0] d, logic [31:0] m);
    int n;
    n = 0;
    avs_write <= wr;
    avs_read <= !wr;
    avs_address <= a;
    avs_writedata <= d;
    if (!wr) notes.push_back({d, m});
    do begin
      @(posedge clk_i);
      n++;
    end while (avs_waitrequest !== 1'b0 && n < 50);
    if (avs_waitrequest !== 1'b0) begin
      failures++;
      tally_and_finish();
    end
    avs_read <= 1'b0;
    avs_write <= 1'b0;
    @(posedge clk_i);
  endtask
  always @(posedge clk_i) begin
    if (avs_read && avs_waitrequest === 1'b0) begin
      nt = notes.pop_front();
      check("readdata", nt[63:32], avs_readdata & nt[31:0]);
    end
  end
  task automatic wait_ctl(logic [1:0] v, int lim);
    int n;
    n = 0;
    while (phase_ctl_o !== v && n < lim) begin
      @(posedge clk_i);
      n++;
    end
    check("phase lines", {30'h0, v}, {30'h0, phase_ctl_o});
    if (phase_ctl_o !== v) tally_and_finish();
  endtask
  task automatic wait_digit(int k, logic [3:0] v);
    int n;
    n = 0;
    do begin
      @(posedge clk_i);
      n++;
    end while (digit_en_o !== 5'(1 << k) && n < 100);
    check("digit enable", {27'h0, 5'(1 << k)}, {27'h0, digit_en_o});
    check("digit", {28'h0, v}, {28'h0, bcd_o});
    if (digit_en_o !== 5'(1 << k)) tally_and_finish();
  endtask
  initial begin
    nrst_i = 1'b0;
    trigger_i = 1'b0;
    avs_read = 1'b0;
    avs_write = 1'b0;
    avs_address = 4'h0;
    avs_writedata = 32'h0;
    avs_byteenable = 4'he;
    void'($urandom(32'hf1e0));
    ref_steps = 16'(10 * (10 + $urandom % 9));
    pos = 1'($urandom % 2);
    repeat (16) @(posedge clk_i);
    nrst_i <= 1'b1;
    @(posedge clk_i);
    check("idle", 32'h0, {24'h0, phase_ctl_o, over_range_o, digit_en_o});
    // A control write without the low byte enable must be dropped
    bus(1'b1, REG_CTRL, 32'h1, 32'h0);
    bus(1'b0, REG_CTRL, 32'h0, 32'h3);
    avs_byteenable <= 4'hf;
    bus(1'b1, REG_CTRL, 32'h1, 32'h0);
    bus(1'b0, REG_CTRL, 32'h1, 32'h3);
    bus(1'b1, REG_CTRL, 32'h0, 32'h0);
    bus(1'b1, 4'h2, $urandom, 32'h0);
    bus(1'b0, 4'h2, 32'h0, 32'hffff_ffff);
    bus(1'b0, REG_RESULT, 32'h0, 32'hffff_ffff);
    $display("test registers done");
    repeat (40100) @(posedge clk_i);
    bus(1'b0, REG_STATUS, 32'h1, 32'h3);
    bus(1'b0, REG_COUNT, 32'h4e20, 32'hffff_ffff);
    repeat (50) @(posedge clk_i);
    bus(1'b0, REG_COUNT, 32'h4e20, 32'hffff_ffff);
    trigger_i <= 1'b1;
    repeat (20) @(posedge clk_i);
    bus(1'b0, REG_STATUS, 32'h0, 32'h3);
    $display("test hold done");
    wait_ctl(2'b11, 20100);
    wait_ctl({pos, !pos}, 20010);
    wait_ctl(2'b00, 2 * int'(ref_steps) + 40);
    repeat (4) @(posedge clk_i);
    // Low digit may trail by the comparator synchroniser
    expv = 32'h100 | (32'((ref_steps / 10) % 10) << 4) | (32'(pos) << 21);
    bus(1'b0, REG_RESULT, expv, 32'hffff_fffc);
    check("over range", 32'h0, {31'h0, over_range_o});
    check("sign", {31'h0, pos}, {31'h0, sign_o});
    $display("test conversion done");
    wait_digit(2, 4'h1);
    wait_digit(1, 4'((ref_steps / 10) % 10));
    wait_digit(4, 4'h0);
    $display("test display done");
    // Software blanking darkens every digit whatever the result
    bus(1'b1, REG_CTRL, 32'h2, 32'h0);
    repeat (8) @(posedge clk_i);
    check("blanked enable", 32'h0, {27'h0, digit_en_o});
    check("blanked digit", 32'hf, {28'h0, bcd_o});
    bus(1'b1, REG_CTRL, 32'h0, 32'h0);
    $display("test blanking done");
    tally_and_finish();
  end
endmodule
bind adcs_seq adcs_seq_chk i_adcs_seq_chk (.clk_i(clk_i), .nrst_i(nrst_i),
  .comparator_i(comparator_i), .phase_ctl_o(phase_ctl_o), .digit_en_o(digit_en_o),
  .over_range_o(over_range_o), .avs_read(avs_read), .avs_waitrequest(avs_waitrequest));
